// ---- rtl/rdq_pkg.sv ----
// shared constants, types and register map of the receive done queue manager
package rdq_pkg;
   // register byte offsets on the avalon slave
   localparam logic [11:0] RDQ_OFS_BASE_LO = 12'h0730;
   localparam logic [11:0] RDQ_OFS_BASE_HI = 12'h0734;
   localparam logic [11:0] RDQ_OFS_END = 12'h0738;
   localparam logic [11:0] RDQ_OFS_RD_PTR = 12'h073C;
   localparam logic [11:0] RDQ_OFS_WR_PTR = 12'h0740;
   localparam logic [11:0] RDQ_OFS_TIMER = 12'h0744;
   localparam logic [11:0] RDQ_OFS_QCTRL = 12'h0780;
   localparam logic [11:0] RDQ_OFS_STATUS = 12'h0790;
   localparam logic [11:0] RDQ_OFS_IRQ_EN = 12'h0794;
   localparam logic [11:0] RDQ_OFS_MASTER = 12'h0798;
   // receive_queue_control field positions
   localparam int RDQ_BIT_BURST_EN = 4;
   localparam int RDQ_BIT_FLUSH = 5;
   localparam int RDQ_POS_STAT_THR = 8;
   // status / irq enable field positions
   localparam int RDQ_BIT_WRITE_FLAG = 0;
   localparam int RDQ_BIT_OVFL_FLAG = 1;
   // master control field position
   localparam int RDQ_BIT_DMA_EN = 0;
   // values after reset
   localparam logic [15:0] RDQ_RST_REG16 = 16'h0000;
   localparam logic [31:0] RDQ_RST_WORD = 32'h0000_0000;
   // queue geometry and counts
   localparam logic [15:0] RDQ_PTR_STEP = 16'h0004;
   localparam logic [15:0] RDQ_PTR_WRAP = 16'h0000;
   localparam int RDQ_FIFO_DEPTH = 8;
   localparam logic [3:0] RDQ_FIFO_FULL = 4'h8;
   localparam logic [3:0] RDQ_HIGH_WATER = 4'h6;
   localparam int RDQ_CHANNELS = 256;
   localparam logic [7:0] RDQ_TICK_DIV_LAST = 8'hFF;
   localparam logic [2:0] RDQ_STAT_RESERVED = 3'b111;
   localparam logic [2:0] RDQ_STAT_PCI_ERR = 3'b110;

   // drain state machine, one-hot
   typedef enum logic [1:0] {
      RDQ_ST_IDLE = 2'b01,
      RDQ_ST_SEND = 2'b10
   } rdq_state_e;

   // one buffer event from the receive data path
   typedef struct packed {
      logic [15:0] desc_ptr;   // descriptor offset from descriptor base
      logic [8:0] chan_num;    // channel number 1..256
      logic [2:0] threshold;   // channel buffer threshold 0..7
      logic eof;               // last buffer of the packet
      logic [2:0] pkt_status;  // final packet status, valid with eof
   } rdq_event_s;

   // one completion descriptor as written to host memory
   typedef struct packed {
      logic valid_n;           // written as zero
      logic eof;
      logic [2:0] pkt_status;
      logic [2:0] buf_count;
      logic [7:0] chan_code;
      logic [15:0] desc_ptr;
   } rdq_desc_s;
endpackage

// ---- rtl/rdq_manager.sv ----
// receive done queue manager: completion descriptor build, fifo and host queue writer
// Overview of operation
// - low 16 bits carry descriptor offset
// - bits 23:16 carry channel number minus one
// - buffer count zero when packet-only reporting
// - short packet reports buffers actually filled
// - packet status code, 111 never produced
// - bit 30 marks end of chain
// - bit 31 always written zero
// - queue empty when pointers equal
// - queue full when read one ahead
// - device owns write pointer, host read pointer
// - end value is relative to base
// - write address is base plus pointer
// - pointer steps one dword, wraps past end
// - write flag after every or counted writes
// - overflow sets error flag, no write
// - each flag can raise enabled interrupt
// - post per threshold and always at end
// - eight entry completion burst fifo
// - burst mode waits for six entries
// - burst writes only what fits, else error
// - burst advances pointer and sets flag
// - without burst mode entries go singly
// - flush timer ticks per 256 clocks
// - flush bit pushes fifo to host queue
// - threshold code n means 2^n writes
`timescale 1ns/1ps
`default_nettype none
module rdq_manager
   import rdq_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   // avalon-mm register slave
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // buffer events from the receive path
   input wire logic evt_valid,
   input wire rdq_event_s evt_data,
   output logic evt_ready,
   // single dword writes toward host memory
   output logic mem_valid,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_data,
   output logic mem_last,
   input wire logic mem_ready,
   // interrupt request
   output logic irq
);
   // ---------------- register state ----------------
   logic [15:0] base_lo_q, base_hi_q, end_q, rd_ptr_q, wr_ptr_q, timer_reg_q;
   logic [15:0] wr_ptr_d;
   logic [31:0] qctrl_q, irq_en_q, master_q;
   logic [1:0] status_q, status_d;
   logic [31:0] rdata_q;
   logic wait_q;
   logic irq_q;

   // bus decode
   wire logic req = avs_read | avs_write;
   wire logic commit = req & ~wait_q;
   wire logic wr_commit = commit & avs_write;
   wire logic [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire logic sel_base_lo = avs_address == RDQ_OFS_BASE_LO;
   wire logic sel_base_hi = avs_address == RDQ_OFS_BASE_HI;
   wire logic sel_end = avs_address == RDQ_OFS_END;
   wire logic sel_rd_ptr = avs_address == RDQ_OFS_RD_PTR;
   wire logic sel_wr_ptr = avs_address == RDQ_OFS_WR_PTR;
   wire logic sel_timer = avs_address == RDQ_OFS_TIMER;
   wire logic sel_qctrl = avs_address == RDQ_OFS_QCTRL;
   wire logic sel_status = avs_address == RDQ_OFS_STATUS;
   wire logic sel_irq_en = avs_address == RDQ_OFS_IRQ_EN;
   wire logic sel_master = avs_address == RDQ_OFS_MASTER;

   // control bits
   wire logic dma_en = master_q[RDQ_BIT_DMA_EN];
   wire logic burst_en = qctrl_q[RDQ_BIT_BURST_EN];
   wire logic flush_req = qctrl_q[RDQ_BIT_FLUSH];
   wire logic [2:0] stat_thr = qctrl_q[RDQ_POS_STAT_THR +: 3];

   // merged write data for 16 and 32 bit registers
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   // read mux, unmapped addresses read as zero and reserved bits as zero
   logic [31:0] rmux;
   always_comb begin
      rmux = RDQ_RST_WORD;
      if (sel_base_lo) rmux = {16'h0000, base_lo_q};
      if (sel_base_hi) rmux = {16'h0000, base_hi_q};
      if (sel_end) rmux = {16'h0000, end_q};
      if (sel_rd_ptr) rmux = {16'h0000, rd_ptr_q};
      if (sel_wr_ptr) rmux = {16'h0000, wr_ptr_q};
      if (sel_timer) rmux = {16'h0000, timer_reg_q};
      if (sel_qctrl) rmux = qctrl_q;
      if (sel_status) rmux = {30'h0000_0000, status_q};
      if (sel_irq_en) rmux = irq_en_q;
      if (sel_master) rmux = master_q;
   end

   // bus handshake: one wait cycle, then the request is taken with waitrequest low
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wait_q <= 1'b1;
         rdata_q <= RDQ_RST_WORD;
      end else begin
         wait_q <= ~(req & wait_q);
         if (req & wait_q) begin
            rdata_q <= rmux;
         end
      end
   end

   // host-owned configuration registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         base_lo_q <= RDQ_RST_REG16;
         base_hi_q <= RDQ_RST_REG16;
         end_q <= RDQ_RST_REG16;
         rd_ptr_q <= RDQ_RST_REG16;
         timer_reg_q <= RDQ_RST_REG16;
         qctrl_q <= RDQ_RST_WORD;
         irq_en_q <= RDQ_RST_WORD;
         master_q <= RDQ_RST_WORD;
      end else if (wr_commit) begin
         if (sel_base_lo) base_lo_q <= 16'(merge(32'(base_lo_q), avs_writedata, be_mask));
         if (sel_base_hi) base_hi_q <= 16'(merge(32'(base_hi_q), avs_writedata, be_mask));
         if (sel_end) end_q <= 16'(merge(32'(end_q), avs_writedata, be_mask));
         // only the host moves the read pointer
         if (sel_rd_ptr) rd_ptr_q <= 16'(merge(32'(rd_ptr_q), avs_writedata, be_mask));
         if (sel_timer) timer_reg_q <= 16'(merge(32'(timer_reg_q), avs_writedata, be_mask));
         if (sel_qctrl) qctrl_q <= merge(qctrl_q, avs_writedata, be_mask) & 32'h0000_0730;
         if (sel_irq_en) irq_en_q <= merge(irq_en_q, avs_writedata, be_mask) & 32'h0000_0003;
         if (sel_master) master_q <= merge(master_q, avs_writedata, be_mask) & 32'h0000_0001;
      end
   end

   // ---------------- queue pointer arithmetic ----------------
   // next pointer: one dword on, back to the base once past the relative end
   function automatic logic [15:0] next_ptr(input logic [15:0] p, input logic [15:0] e);
      logic [15:0] n;
      n = p + RDQ_PTR_STEP;
      next_ptr = (n > e) ? RDQ_PTR_WRAP : n;
   endfunction

   wire logic [15:0] wp_next = next_ptr(wr_ptr_q, end_q);
   wire logic [15:0] wp_next2 = next_ptr(wp_next, end_q);
   wire logic q_empty = rd_ptr_q == wr_ptr_q;
   wire logic q_full = rd_ptr_q == wp_next;
   wire logic q_full_after = rd_ptr_q == wp_next2;
   // absolute address is the full base plus the pointer
   wire logic [31:0] q_addr = {base_hi_q, base_lo_q} + {16'h0000, wr_ptr_q};

   // ---------------- completion descriptor build ----------------
   logic [2:0] buf_cnt [RDQ_CHANNELS]; // buffers filled since last post, per channel
   wire logic [7:0] chan_code = 8'(evt_data.chan_num - 9'd1);
   wire logic [2:0] cnt_new = buf_cnt[chan_code] + 3'd1;
   wire logic thr_hit = (evt_data.threshold != 3'b000) && (cnt_new == evt_data.threshold);
   wire logic evt_take = evt_valid & evt_ready;
   wire logic do_post = evt_take & (evt_data.eof | thr_hit);
   wire logic [2:0] cnt_store = (do_post || evt_data.threshold == 3'b000) ? 3'd0 : cnt_new;
   // reserved status code is never passed on
   wire logic [2:0] stat_clean = (evt_data.pkt_status == RDQ_STAT_RESERVED) ?
                                 RDQ_STAT_PCI_ERR : evt_data.pkt_status;
   rdq_desc_s new_desc;
   always_comb begin
      new_desc.desc_ptr = evt_data.desc_ptr;
      new_desc.chan_code = chan_code;
      // packet-only channels report zero, others the buffers filled so far
      new_desc.buf_count = (evt_data.threshold == 3'b000) ? 3'd0 : cnt_new;
      new_desc.pkt_status = evt_data.eof ? stat_clean : 3'b000;
      new_desc.eof = evt_data.eof;
      new_desc.valid_n = 1'b0;
   end

   // per-channel buffer counters, one per entry
   genvar g;
   generate
      for (g = 0; g < RDQ_CHANNELS; g++) begin : gen_cnt
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               buf_cnt[g] <= 3'd0;
            end else if (evt_take && chan_code == 8'(g)) begin
               buf_cnt[g] <= cnt_store;
            end
         end
      end
   endgenerate

   // ---------------- eight entry burst fifo ----------------
   logic [31:0] fifo_mem [RDQ_FIFO_DEPTH];
   logic [2:0] rd_idx_q, wr_idx_q;
   logic [3:0] count_q, count_d;
   logic pop;
   wire logic push = do_post;
   assign count_d = count_q + {3'b000, push} - {3'b000, pop};

   // fifo storage, data needs no reset
   always_ff @(posedge clk_sys) begin
      if (push) begin
         fifo_mem[wr_idx_q] <= new_desc;
      end
   end

   // fifo indices and input back-pressure, ready is exact for the next cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_idx_q <= 3'd0;
         wr_idx_q <= 3'd0;
         count_q <= 4'd0;
         evt_ready <= 1'b0;
      end else begin
         rd_idx_q <= rd_idx_q + {2'b00, pop};
         wr_idx_q <= wr_idx_q + {2'b00, push};
         count_q <= count_d;
         evt_ready <= count_d < RDQ_FIFO_FULL;
      end
   end

   // ---------------- flush timer ----------------
   logic [7:0] presc_q;
   logic [15:0] timer_q;
   logic timer_due_q;
   wire logic tick = presc_q == RDQ_TICK_DIV_LAST;
   wire logic q_write = mem_valid & mem_ready;

   // counts down every 256 clocks in burst mode, reloaded on every queue write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         presc_q <= 8'd0;
         timer_q <= RDQ_RST_REG16;
         timer_due_q <= 1'b0;
      end else begin
         presc_q <= presc_q + 8'd1;
         if (q_write || !burst_en) begin
            timer_q <= timer_reg_q;
            timer_due_q <= 1'b0;
         end else if (tick && timer_q != 16'h0000) begin
            // zero is an illegal load and simply never expires
            timer_q <= timer_q - 16'h0001;
            if (timer_q == 16'h0001) begin
               timer_due_q <= 1'b1;
            end
         end
      end
   end

   // ---------------- drain state machine ----------------
   rdq_state_e state_q, state_d;
   logic [7:0] wcount_q, wcount_d;
   logic load, set_write, set_ovfl;
   // burst mode waits for the high water mark, the flush bit or the timer
   wire logic trigger = dma_en && count_q != 4'd0 &&
                        (!burst_en || count_q >= RDQ_HIGH_WATER || flush_req || timer_due_q);
   // stop after this entry when the fifo runs dry, the queue fills, or entries go singly
   wire logic last_now = (count_q == 4'd1) || q_full_after || !burst_en;
   wire logic [8:0] thr_span = 9'd1 << stat_thr;
   wire logic [7:0] wcount_inc = wcount_q + 8'd1;

   always_comb begin
      state_d = state_q;
      load = 1'b0;
      pop = 1'b0;
      set_write = 1'b0;
      set_ovfl = 1'b0;
      wcount_d = wcount_q;
      wr_ptr_d = wr_ptr_q;
      case (state_q)
         RDQ_ST_IDLE: begin
            if (trigger) begin
               if (q_full) begin
                  // no room at all: flag it, write nothing, keep the pointer
                  set_ovfl = 1'b1;
               end else begin
                  load = 1'b1;
                  state_d = RDQ_ST_SEND;
               end
            end
         end
         RDQ_ST_SEND: begin
            if (mem_ready) begin
               pop = 1'b1;
               wr_ptr_d = wp_next;
               // write flag after 2^n or more writes
               if ({1'b0, wcount_inc} >= thr_span) begin
                  set_write = 1'b1;
                  wcount_d = 8'd0;
               end else begin
                  wcount_d = wcount_inc;
               end
               if (!mem_last) begin
                  load = 1'b1;
               end else begin
                  state_d = RDQ_ST_IDLE;
               end
            end
         end
         default: begin
            state_d = RDQ_ST_IDLE;
         end
      endcase
      // host may place the write pointer only while the dma is stopped
      if (wr_commit && sel_wr_ptr && !dma_en) begin
         wr_ptr_d = 16'(merge(32'(wr_ptr_q), avs_writedata, be_mask));
      end
   end

   // next fifo entry, one ahead when the current one is being accepted
   wire logic [2:0] load_idx = (state_q == RDQ_ST_SEND) ? rd_idx_q + 3'd1 : rd_idx_q;
   wire logic [15:0] load_ptr = (state_q == RDQ_ST_SEND) ? wp_next : wr_ptr_q;
   wire logic [31:0] load_addr = {base_hi_q, base_lo_q} + {16'h0000, load_ptr};
   // full and last tests for an entry loaded back to back inside a burst
   wire logic next_last = (count_q == 4'd2) || (rd_ptr_q == next_ptr(wp_next2, end_q));

   // status flags are sticky, hardware set wins over the host clear
   always_comb begin
      status_d = status_q;
      if (wr_commit && sel_status) begin
         status_d = status_q & ~(avs_writedata[1:0] & {2{avs_byteenable[0]}});
      end
      if (set_write) status_d[RDQ_BIT_WRITE_FLAG] = 1'b1;
      if (set_ovfl) status_d[RDQ_BIT_OVFL_FLAG] = 1'b1;
   end

   // drain registers and host memory write port
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= RDQ_ST_IDLE;
         wcount_q <= 8'd0;
         wr_ptr_q <= RDQ_RST_REG16;
         status_q <= 2'b00;
         irq_q <= 1'b0;
         mem_valid <= 1'b0;
         mem_addr <= RDQ_RST_WORD;
         mem_data <= RDQ_RST_WORD;
         mem_last <= 1'b0;
      end else begin
         state_q <= state_d;
         wcount_q <= wcount_d;
         wr_ptr_q <= wr_ptr_d;
         status_q <= status_d;
         // each flag reaches the interrupt line only through its enable
         irq_q <= |(status_d & irq_en_q[1:0]);
         if (load) begin
            mem_valid <= 1'b1;
            mem_addr <= load_addr;
            mem_data <= fifo_mem[load_idx];
            mem_last <= (state_q == RDQ_ST_SEND) ? (next_last || !burst_en) : last_now;
         end else if (mem_ready) begin
            mem_valid <= 1'b0;
            mem_last <= 1'b0;
         end
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign irq = irq_q;
   // q_empty and q_addr document the queue view; the loaded address is load_addr
   wire logic unused_ok = q_empty ^ q_addr[0];
endmodule
`default_nettype wire

// ---- sim/rdq_manager_asserts.sv ----
// port-level checks of the receive done queue manager
`timescale 1ns/1ps
`default_nettype none
module rdq_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic mem_valid,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_data,
   input wire logic mem_last,
   input wire logic mem_ready
);
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // the host polls bit 31, so it must always leave cleared
   a_valid_bit_zero: assert property (mem_valid |-> !mem_data[31])
      else $error("completion written with bit 31 set");
   a_status_legal: assert property (mem_valid |-> mem_data[29:27] != 3'h7)
      else $error("reserved packet status written");
   // a post in mid chain only happens on a buffer threshold
   a_mid_count: assert property (mem_valid && !mem_data[30] |-> mem_data[26:24] != 3'h0)
      else $error("mid chain post with zero buffer count");
   // a stalled write must not move under the memory side
   a_mem_hold: assert property (mem_valid && !mem_ready |=>
      mem_valid && $stable(mem_addr) && $stable(mem_data))
      else $error("queue write changed before acceptance");
   a_burst_run: assert property (mem_valid && mem_ready && !mem_last |=> mem_valid)
      else $error("burst stopped before its last dword");
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |->
      ##[1:2] !avs_waitrequest)
      else $error("register access not answered");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 12'h7FC
      |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read returned data");
endmodule
`default_nettype wire

// ---- sim/rdq_host_mem.sv ----
// host memory stand-in that accepts completion dword writes
`timescale 1ns/1ps
`default_nettype none
module rdq_host_mem (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic slow,
   input wire logic mem_valid,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_data,
   output logic mem_ready
);
   logic [63:0] log_q[$]; // accepted writes, address above data
   // slow mode answers every other cycle, which stretches bursts
   always @(posedge clk_sys) begin
      if (rst) begin
         mem_ready <= 1'b0;
      end else begin
         mem_ready <= slow ? !mem_ready : 1'b1;
         if (mem_valid && mem_ready) begin
            log_q.push_back({mem_addr, mem_data});
         end
      end
   end
endmodule
`default_nettype wire

// ---- sim/rdq_manager_bench.sv ----
// self-checking bench of the receive done queue manager
`timescale 1ns/1ps
`default_nettype none
module rdq_manager_bench import rdq_pkg::*;;
   localparam logic [31:0] BASE = 32'h0002_1000; // queue base in host memory
   localparam logic [15:0] QEND = 16'h001C; // eight slots of one dword
   logic clk_sys, rst, avs_read, avs_write, avs_waitrequest;
   logic evt_valid, evt_ready, mem_valid, mem_last, mem_ready, irq, slow;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, mem_addr, mem_data, q;
   logic [3:0] avs_byteenable;
   rdq_event_s evt_data;
   logic [15:0] wp; // expected device write pointer
   logic [8:0] ch;
   logic [2:0] st;
   int mismatches, comparisons;
   int cycles = 0;

   rdq_manager dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .evt_valid(evt_valid), .evt_data(evt_data),
      .evt_ready(evt_ready), .mem_valid(mem_valid), .mem_addr(mem_addr),
      .mem_data(mem_data), .mem_last(mem_last), .mem_ready(mem_ready), .irq(irq));
   rdq_host_mem mem_u (.clk_sys(clk_sys), .rst(rst), .slow(slow), .mem_valid(mem_valid),
      .mem_addr(mem_addr), .mem_data(mem_data), .mem_ready(mem_ready));

   always #12.5 clk_sys = !clk_sys;

   // verdict and end of run
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ceiling far above the few hundred cycles the sequence needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // avalon transfer, held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0000_0000);
      chk(what, exp, q);
   endtask
   // pointer step with wrap once past the end offset
   function automatic logic [15:0] nxt(input logic [15:0] p);
      return (p + RDQ_PTR_STEP > QEND) ? RDQ_PTR_WRAP : p + RDQ_PTR_STEP;
   endfunction
   // host consumes everything written so far
   task automatic eat();
      bus(1'b1, RDQ_OFS_RD_PTR, {16'h0000, wp});
   endtask
   // one buffer event, held until the fifo takes it
   task automatic send(input logic [15:0] p, input logic [8:0] c, input logic [2:0] th,
      input logic e, input logic [2:0] s);
      evt_data <= {p, c, th, e, s};
      evt_valid <= 1'b1;
      @(posedge clk_sys);
      while (evt_ready !== 1'b1) @(posedge clk_sys);
      evt_valid <= 1'b0;
      @(posedge clk_sys);
   endtask
   // next captured host write against the expected descriptor
   task automatic post(input logic [15:0] p, input logic [8:0] c, input logic [2:0] n,
      input logic e, input logic [2:0] s);
      logic [8:0] code;
      logic [63:0] w;
      code = c - 9'h001;
      while (mem_u.log_q.size() == 0) @(posedge clk_sys);
      w = mem_u.log_q.pop_front(); // entry now read, as a polling host would
      chk("queue address", BASE + {16'h0000, wp}, w[63:32]);
      chk("descriptor", {1'b0, e, s, n, code[7:0], p}, w[31:0]);
      wp = nxt(wp);
   endtask
   // registered outputs settle, then are sampled away from the edge
   task automatic calm();
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      avs_address = 12'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      evt_valid = 1'b0;
      evt_data = '0;
      slow = 1'b0;
      wp = 16'h0000;
      mismatches = 0;
      comparisons = 0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      // queue registers leave reset cleared
      for (int i = 0; i < 6; i++) begin
         rd_chk(RDQ_OFS_BASE_LO + 12'(4 * i), RDQ_RST_WORD, "reset value");
      end
      rd_chk(12'h7FC, 32'h0000_0000, "unmapped read");
      bus(1'b1, RDQ_OFS_BASE_LO, 32'h0000_1000);
      bus(1'b1, RDQ_OFS_BASE_HI, 32'h0000_0002);
      bus(1'b1, RDQ_OFS_END, {16'h0000, QEND});
      bus(1'b1, RDQ_OFS_IRQ_EN, 32'h0000_0003);
      bus(1'b1, RDQ_OFS_MASTER, 32'h0000_0001);
      // the write pointer belongs to the device once it runs
      bus(1'b1, RDQ_OFS_WR_PTR, 32'h0000_0008);
      rd_chk(RDQ_OFS_WR_PTR, 32'h0000_0000, "write pointer");
      // single writes: every status code, channels 1 to 256, wrap past the end
      for (int i = 0; i < 8; i++) begin
         ch = (i == 7) ? 9'h100 : 9'(1 + 36 * i);
         st = (i == 7) ? RDQ_STAT_PCI_ERR : 3'(i);
         send(16'h0100, ch, 3'h0, 1'b1, 3'(i));
         post(16'h0100, ch, 3'h0, 1'b1, st);
         eat();
      end
      rd_chk(RDQ_OFS_STATUS, 32'h0000_0001, "write flag");
      calm();
      chk("irq raised", 32'h0000_0001, {31'h0, irq});
      @(posedge clk_sys);
      bus(1'b1, RDQ_OFS_STATUS, 32'h0000_0003);
      // threshold two: two buffers post mid chain, the short tail posts at its end
      bus(1'b1, RDQ_OFS_QCTRL, 32'h0000_0100);
      send(16'h0200, 9'h005, 3'h2, 1'b0, 3'h0);
      send(16'h0200, 9'h005, 3'h2, 1'b0, 3'h0);
      post(16'h0200, 9'h005, 3'h2, 1'b0, 3'h0);
      eat();
      rd_chk(RDQ_OFS_STATUS, 32'h0000_0000, "flag after one");
      send(16'h0200, 9'h005, 3'h2, 1'b1, 3'h2);
      post(16'h0200, 9'h005, 3'h1, 1'b1, 3'h2);
      eat();
      rd_chk(RDQ_OFS_STATUS, 32'h0000_0001, "flag after two");
      // full queue: read pointer one slot ahead refuses the entry
      bus(1'b1, RDQ_OFS_RD_PTR, {16'h0000, nxt(wp)});
      send(16'h0300, 9'h007, 3'h0, 1'b1, 3'h0);
      calm();
      chk("held writes", 32'h0000_0000, 32'(mem_u.log_q.size()));
      chk("irq overflow", 32'h0000_0001, {31'h0, irq});
      @(posedge clk_sys);
      rd_chk(RDQ_OFS_STATUS, 32'h0000_0003, "overflow flag");
      bus(1'b1, RDQ_OFS_IRQ_EN, 32'h0000_0000);
      calm();
      chk("irq masked", 32'h0000_0000, {31'h0, irq});
      @(posedge clk_sys);
      bus(1'b1, RDQ_OFS_IRQ_EN, 32'h0000_0003);
      eat();
      post(16'h0300, 9'h007, 3'h0, 1'b1, 3'h0);
      eat();
      bus(1'b1, RDQ_OFS_STATUS, 32'h0000_0003);
      calm();
      chk("irq cleared", 32'h0000_0000, {31'h0, irq});
      @(posedge clk_sys);
      // burst mode with a stalling memory: room for three only
      slow <= 1'b1;
      bus(1'b1, RDQ_OFS_TIMER, 32'h0000_FFFF);
      bus(1'b1, RDQ_OFS_QCTRL, 32'h0000_0010);
      bus(1'b1, RDQ_OFS_RD_PTR, {16'h0000, (wp + 16'h0010) & 16'h001F});
      for (int k = 0; k < 5; k++) send(16'h0400 + 16'(k), 9'h009, 3'h0, 1'b1, 3'h0);
      calm();
      chk("below high water", 32'h0000_0000, 32'(mem_u.log_q.size()));
      @(posedge clk_sys);
      send(16'h0405, 9'h009, 3'h0, 1'b1, 3'h0);
      for (int k = 0; k < 3; k++) post(16'h0400 + 16'(k), 9'h009, 3'h0, 1'b1, 3'h0);
      for (int k = 6; k < 11; k++) send(16'h0400 + 16'(k), 9'h009, 3'h0, 1'b1, 3'h0);
      calm();
      chk("fifo refuses", 32'h0000_0000, {31'h0, evt_ready});
      chk("nothing fits", 32'h0000_0000, 32'(mem_u.log_q.size()));
      @(posedge clk_sys);
      eat();
      for (int k = 3; k < 10; k++) post(16'h0400 + 16'(k), 9'h009, 3'h0, 1'b1, 3'h0);
      rd_chk(RDQ_OFS_STATUS, 32'h0000_0003, "burst flags");
      eat();
      bus(1'b1, RDQ_OFS_QCTRL, 32'h0000_0030);
      post(16'h040A, 9'h009, 3'h0, 1'b1, 3'h0);
      bus(1'b1, RDQ_OFS_TIMER, 32'h0000_0001);
      bus(1'b1, RDQ_OFS_QCTRL, 32'h0000_0000);
      bus(1'b1, RDQ_OFS_QCTRL, 32'h0000_0010);
      send(16'h040B, 9'h009, 3'h0, 1'b1, 3'h0);
      post(16'h040B, 9'h009, 3'h0, 1'b1, 3'h0);
      stop_test();
   end
endmodule
bind rdq_manager rdq_checker chk_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .mem_valid(mem_valid), .mem_addr(mem_addr),
   .mem_data(mem_data), .mem_last(mem_last), .mem_ready(mem_ready));
`default_nettype wire
